// ==== common/spi_chain_consts.vh ====
`ifndef SPI_CHAIN_CONSTS_VH
`define SPI_CHAIN_CONSTS_VH

// ----------------------------------------------------------------------
// Byte and frame layout
// ----------------------------------------------------------------------
`define BYTE_BITS 8
`define BITS_PER_SLAVE 16
`define ADDR_ONE_BIT 0
`define TOKEN_BIT 1
`define ADDR_LO_BIT 2
`define ADDR_HI_BIT 6
`define OP_BIT 7

// ----------------------------------------------------------------------
// Global status layout
// ----------------------------------------------------------------------
`define GS_SPI_ERR_BIT 7
`define GS_POWER_ON_RESET_N_BIT_BIT 4
`define GS_RESET_VAL 8'h00

`endif

// ==== design/sync_two_ff.v ====
`timescale 1ns/100ps
`default_nettype none

module sync_two_ff #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire arst_n,
    input wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);

    // ------------------------------------------------------------------
    // Two flops; the first is read only by the second.
    // ------------------------------------------------------------------
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule // sync_two_ff

`default_nettype wire

// ==== design/spi_frame_daisy_chain_slave.v ====
// Contract
// - Own chip select: one address byte then one data byte, 16 bits.
// - Operation bit 0 reads only; 1 writes or clears.
// - Register address comes from address byte bits 6 to 2.
// - During address byte, output shows error flag then global status.
// - Second byte carries configuration data or a status request.
// - During the data byte, output shifts the addressed register contents.
// - Before first rising clock, output shows error flag ORed with input.
// - Status bytes reach the master in reverse chain order.
// - Response bytes reach the master in reverse chain order.
// - Zero-clock frame still shows the error flag on the output.
// - Faults arising late in a frame appear in the next status.
// - A clear is dropped if its register gets a new fault.
// - Fault during the data byte shows in response, status next frame.
// - Input sampled on falling clock, output changes on rising clock.
// - Error flag is OR of status bits with reset bit inverted.
// - Bad count, address LSB, token, address or clock level sets error.
// - Command acts only when chip select rises at frame end.
`timescale 1ns/100ps
`default_nettype none
`include "spi_chain_consts.vh"

module spi_frame_daisy_chain_slave #(
    parameter CHAIN_W = 4,
    parameter CNT_W = 12,
    parameter [31:0] USED_ADDR_MASK = 32'hFFFF_FFFF
) (
    input wire SYS_CLK,
    input wire ARST_N,
    input wire CHIP_SELECT_N,
    input wire SCLK,
    input wire SDI,
    output reg SDO_OUT,
    output reg SDO_OE,
    input wire [CHAIN_W-1:0] CHAIN_LEN,
    input wire [CHAIN_W-1:0] CHAIN_OFFSET,
    input wire [6:0] STATUS_IN,
    input wire SPI_ERR_CLR,
    input wire FAULT_EVT,
    input wire [4:0] FAULT_REG,
    input wire [7:0] REG_RD_DATA,
    output reg [4:0] REG_ADDR,
    output reg CMD_VALID,
    output reg [4:0] CMD_ADDR,
    output reg CMD_OP,
    output reg [7:0] CMD_DATA,
    output reg CMD_CLEAR_BLOCKED,
    output reg PROTOCOL_ERR,
    output reg GLOBAL_ERROR_FLAG
);

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    wire [2:0] pins_s;
    wire chip_select_n_s;
    wire sclk_s;
    wire sdi_s;

    sync_two_ff #(.WIDTH(3), .INIT(3'h4)) u_sync (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .d({CHIP_SELECT_N, SCLK, SDI}),
        .q(pins_s)
    );

    assign chip_select_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s = pins_s[0];

    reg cs_prev_q;
    reg sclk_prev_q;
    wire in_frame = ~chip_select_n_s;
    wire cs_fall = cs_prev_q & ~chip_select_n_s;
    wire cs_rise = ~cs_prev_q & chip_select_n_s;
    wire sclk_rise = in_frame & ~cs_fall & ~sclk_prev_q & sclk_s;
    wire sclk_fall = in_frame & ~cs_fall & sclk_prev_q & ~sclk_s;

    // ------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------
    reg [CNT_W-1:0] fall_cnt_q;
    reg [CNT_W-1:0] rise_cnt_q;
    reg [7:0] shin_q;
    reg [7:0] dly_q;
    reg [7:0] snap_q;
    reg [7:0] addr_q;
    reg [7:0] data_q;
    reg frm_err_q;
    reg spi_err_q;
    reg [31:0] hit_q;

    wire [CNT_W-1:0] n_w = {{(CNT_W-CHAIN_W){1'b0}}, CHAIN_LEN};
    wire [CNT_W-1:0] off_w = {{(CNT_W-CHAIN_W){1'b0}}, CHAIN_OFFSET};
    wire [CNT_W-1:0] one_w = {{(CNT_W-1){1'b0}}, 1'b1};
    wire [CNT_W-1:0] frame_bits = {n_w[CNT_W-5:0], 4'h0};
    wire [CNT_W-1:0] byte_idx = {3'h0, fall_cnt_q[CNT_W-1:3]};
    wire [CNT_W-1:0] rise_slot = {3'h0, rise_cnt_q[CNT_W-1:3]};
    wire [CNT_W-1:0] last_addr_idx = off_w + n_w - one_w;
    wire [CNT_W-1:0] own_addr_idx = n_w - one_w;
    // Own data sits N bytes after own address, so address and data stay paired.
    wire [CNT_W-1:0] own_data_idx = n_w + n_w - one_w;
    wire [7:0] in_byte = {sdi_s, shin_q[7:1]};
    wire byte_done = sclk_fall & (fall_cnt_q[2:0] == 3'h7);
    wire in_addr_zone = (byte_idx >= off_w) && (byte_idx <= last_addr_idx);
    wire cnt_sat = &fall_cnt_q;

    wire [7:0] status_now = {spi_err_q, STATUS_IN};
    wire gef_now = |(status_now ^ (8'h01 << `GS_POWER_ON_RESET_N_BIT_BIT));

    // a nonzero count must match 16 times the chain length exactly
    wire count_bad = (fall_cnt_q != {CNT_W{1'b0}}) && (fall_cnt_q != frame_bits);
    // clock high at rising chip select edge
    wire cpol_bad = cs_rise & sclk_s;
    // A frame with no clocks carries no address, so the unused-address test is skipped.
    wire end_err = frm_err_q | count_bad | cpol_bad |
        ((fall_cnt_q != {CNT_W{1'b0}}) & ~USED_ADDR_MASK[addr_q[6:2]]);
    wire full_frame = (fall_cnt_q == frame_bits) && (fall_cnt_q != {CNT_W{1'b0}});

    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cs_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
            fall_cnt_q <= {CNT_W{1'b0}};
            rise_cnt_q <= {CNT_W{1'b0}};
            shin_q <= 8'h00;
            dly_q <= 8'h00;
            snap_q <= `GS_RESET_VAL;
            addr_q <= 8'h00;
            data_q <= 8'h00;
            frm_err_q <= 1'b0;
            hit_q <= 32'h0000_0000;
        end else begin
            cs_prev_q <= chip_select_n_s;
            sclk_prev_q <= sclk_s;
            if (cs_fall) begin
                fall_cnt_q <= {CNT_W{1'b0}};
                rise_cnt_q <= {CNT_W{1'b0}};
                shin_q <= 8'h00;
                dly_q <= 8'h00;
                // status is frozen at frame start; later faults wait
                snap_q <= status_now;
                addr_q <= 8'h00;
                data_q <= 8'h00;
                // clock level at falling chip select
                frm_err_q <= sclk_s;
                // a fault in the same cycle still counts
                hit_q <= FAULT_EVT ? (32'h0000_0001 << FAULT_REG) : 32'h0000_0000;
            end else begin
                // remember registers hit by new faults
                if (in_frame && FAULT_EVT) begin
                    hit_q[FAULT_REG] <= 1'b1;
                end
                if (sclk_rise && !(&rise_cnt_q)) begin
                    rise_cnt_q <= rise_cnt_q + one_w;
                end
                if (sclk_fall) begin
                    shin_q <= in_byte;
                    dly_q <= {dly_q[6:0], sdi_s};
                    if (!cnt_sat) begin
                        fall_cnt_q <= fall_cnt_q + one_w;
                    end
                end
                if (byte_done && in_addr_zone) begin
                    if (!in_byte[`ADDR_ONE_BIT]) begin
                        frm_err_q <= 1'b1;
                    end
                    // token only in the final address byte
                    if (in_byte[`TOKEN_BIT] != (byte_idx == last_addr_idx)) begin
                        frm_err_q <= 1'b1;
                    end
                end
                // own address and data picked by position
                if (byte_done && byte_idx == own_addr_idx) begin
                    addr_q <= in_byte;
                end
                if (byte_done && byte_idx == own_data_idx) begin
                    data_q <= in_byte;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------------
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SDO_OUT <= 1'b0;
            SDO_OE <= 1'b0;
        end else begin
            // release the line once chip select is high
            SDO_OE <= in_frame;
            if (!in_frame) begin
                SDO_OUT <= 1'b0;
            end else if (cs_fall || rise_cnt_q == {CNT_W{1'b0}}) begin
                if (sclk_rise) begin
                    SDO_OUT <= snap_q[0];
                end else begin
                    // flag ORed with the upstream input; no clock needed
                    SDO_OUT <= (cs_fall ? gef_now : GLOBAL_ERROR_FLAG) | sdi_s;
                end
            end else if (sclk_rise) begin
                if (rise_slot == {CNT_W{1'b0}}) begin
                    // global status during address byte; own status first
                    SDO_OUT <= snap_q[rise_cnt_q[2:0]];
                end else if (rise_slot == n_w) begin
                    // live register contents; late faults show here
                    SDO_OUT <= REG_RD_DATA[rise_cnt_q[2:0]];
                end else begin
                    // forwarded bytes keep responses in reverse order
                    SDO_OUT <= dly_q[7];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Frame end, command and error flag
    // ------------------------------------------------------------------
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_ADDR <= 5'h00;
            CMD_VALID <= 1'b0;
            CMD_ADDR <= 5'h00;
            CMD_OP <= 1'b0;
            CMD_DATA <= 8'h00;
            CMD_CLEAR_BLOCKED <= 1'b0;
            spi_err_q <= 1'b0;
            PROTOCOL_ERR <= 1'b0;
            GLOBAL_ERROR_FLAG <= 1'b1;
        end else begin
            // address field drives the read mux
            REG_ADDR <= addr_q[`ADDR_HI_BIT:`ADDR_LO_BIT];
            GLOBAL_ERROR_FLAG <= gef_now;
            PROTOCOL_ERR <= spi_err_q;
            // act only on rising chip select of a clean full frame
            CMD_VALID <= cs_rise & full_frame & ~end_err;
            if (cs_rise) begin
                CMD_ADDR <= addr_q[`ADDR_HI_BIT:`ADDR_LO_BIT];
                // operation bit selects read only or write/clear
                CMD_OP <= addr_q[`OP_BIT];
                // data byte taken as configuration or request
                CMD_DATA <= data_q;
                // drop the clear when the target gained a fault
                CMD_CLEAR_BLOCKED <= hit_q[addr_q[6:2]] |
                    (FAULT_EVT && FAULT_REG == addr_q[6:2]);
            end
            // error reported from the next frame; set wins over clear
            if (cs_rise && end_err) begin
                spi_err_q <= 1'b1;
            end else if (SPI_ERR_CLR) begin
                spi_err_q <= 1'b0;
            end
        end
    end

endmodule // spi_frame_daisy_chain_slave

`default_nettype wire

// ==== verif/spi_slave_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module spi_slave_checker (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic CHIP_SELECT_N,
    input wire logic [6:0] STATUS_IN,
    input wire logic SPI_ERR_CLR,
    input wire logic SDO_OUT,
    input wire logic SDO_OE,
    input wire logic CMD_VALID,
    input wire logic PROTOCOL_ERR,
    input wire logic GLOBAL_ERROR_FLAG
);
    // ------------------------------------------------------------
    // Link, command timing and error flag
    // ------------------------------------------------------------
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    property p_idle; CHIP_SELECT_N [*5] |-> !SDO_OE && !SDO_OUT; endproperty
    a_idle: assert property (p_idle) else $error("output not released");
    property p_drive; !CHIP_SELECT_N [*5] |-> SDO_OE; endproperty
    a_drive: assert property (p_drive) else $error("output not driven");
    property p_pulse; CMD_VALID |=> !CMD_VALID; endproperty
    a_pulse: assert property (p_pulse) else $error("command pulse too long");
    property p_cmd_at_end; CMD_VALID |-> $past(CHIP_SELECT_N, 2) && !$past(CHIP_SELECT_N, 8);
    endproperty
    a_cmd_at_end: assert property (p_cmd_at_end) else $error("command off frame end");
    property p_cmd_ok; CMD_VALID |-> !$rose(PROTOCOL_ERR) ##1 !$rose(PROTOCOL_ERR); endproperty
    a_cmd_ok: assert property (p_cmd_ok) else $error("command with error");
    property p_err_at_end; $rose(PROTOCOL_ERR) |-> $past(CHIP_SELECT_N, 2)
        && !$past(CHIP_SELECT_N, 8); endproperty
    a_err_at_end: assert property (p_err_at_end) else $error("error off frame end");
    property p_clr; SPI_ERR_CLR && CHIP_SELECT_N && $past(CHIP_SELECT_N, 8) |-> ##2 !PROTOCOL_ERR;
    endproperty
    a_clr: assert property (p_clr) else $error("error not cleared");
    property p_gef; ($stable(STATUS_IN) && $stable(PROTOCOL_ERR) && $past(ARST_N, 3)) [*4]
        |-> GLOBAL_ERROR_FLAG == (PROTOCOL_ERR | (|(STATUS_IN ^ 7'h10))); endproperty
    a_gef: assert property (p_gef) else $error("error flag wrong");
endmodule // spi_slave_checker
bind spi_frame_daisy_chain_slave spi_slave_checker u_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
    .CHIP_SELECT_N(CHIP_SELECT_N), .STATUS_IN(STATUS_IN), .SPI_ERR_CLR(SPI_ERR_CLR),
    .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE), .CMD_VALID(CMD_VALID), .PROTOCOL_ERR(PROTOCOL_ERR),
    .GLOBAL_ERROR_FLAG(GLOBAL_ERROR_FLAG));
`default_nettype wire

// ==== verif/spi_master_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
    output logic cs_n,
    output logic sck,
    output logic mosi,
    input wire logic miso
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    task automatic frame(input int nb, input logic [63:0] tx, output logic [63:0] rx,
                         output logic flag);
        rx = '0;
        mosi = 1'b0;
        #40 cs_n = 1'b0;
        #80 flag = miso;
        for (int i = 0; i < nb; i++) begin
            sck = 1'b1;
            mosi = tx[i];
            #40 sck = 1'b0;
            rx[i] = miso;
            #40;
        end
        #40 cs_n = 1'b1;
        // Released input toggles so a stale level is never mistaken for data.
        mosi = ~mosi;
        #80;
    endtask
endmodule // spi_master_model
`default_nettype wire

// ==== verif/spi_frame_daisy_chain_slave_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module spi_frame_daisy_chain_slave_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cs_n, sclk, sdi, sdo, oe, clr, fevt, flag, cv, cop, cblk, perr, global_error_flag;
    logic exp_err = 1'b0;
    logic [3:0] len, off;
    logic [6:0] status;
    logic [4:0] freg, raddr, caddr;
    logic [7:0] cdata, regs [32];
    logic [31:0] r, seed = 32'h0000_0031;
    logic [63:0] rx;
    int num_errors = 0, comparisons = 0, ncmd = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (cv === 1'b1) ncmd++;
    spi_frame_daisy_chain_slave #(.USED_ADDR_MASK(32'hFFFF_FFFE)) dut (
        .SYS_CLK(clk), .ARST_N(arst_n), .CHIP_SELECT_N(cs_n), .SCLK(sclk), .SDI(sdi),
        .SDO_OUT(sdo), .SDO_OE(oe), .CHAIN_LEN(len), .CHAIN_OFFSET(off),
        .STATUS_IN(status), .SPI_ERR_CLR(clr), .FAULT_EVT(fevt), .FAULT_REG(freg),
        .REG_RD_DATA(regs[raddr]), .REG_ADDR(raddr), .CMD_VALID(cv), .CMD_ADDR(caddr),
        .CMD_OP(cop), .CMD_DATA(cdata), .CMD_CLEAR_BLOCKED(cblk), .PROTOCOL_ERR(perr),
        .GLOBAL_ERROR_FLAG(global_error_flag));
    spi_master_model mst (.cs_n(cs_n), .sck(sclk), .mosi(sdi), .miso(sdo));
    // ------------------------------------------------------------
    // Helpers and reference model
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] want);
        comparisons++;
        if (got !== want) begin
            num_errors++;
            $display("mismatch at %0t: got %0h want %0h", $time, got, want);
        end
    endtask
    task automatic complete_run();
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmd(input int nb, input logic [63:0] tx);
        logic [7:0] ab, db, st, ev;
        logic g, bad;
        int c0;
        ab = tx[8*len-8 +: 8];
        db = tx[16*len-8 +: 8];
        st = {exp_err, status};
        g = exp_err | (|(status ^ 7'h10));
        c0 = ncmd;
        bad = nb != 0 && (nb != 16 * len || ab[6:2] == 5'h00 || ab[1:0] != {off == 4'h0, 1'b1});
        mst.frame(nb, tx, rx, flag);
        chk(flag, g);
        for (int s = 0; s < 2 * len && !bad && nb != 0; s++) begin
            ev = (s == 0) ? st : (s == len) ? regs[ab[6:2]] : tx[8*s-8 +: 8];
            chk(rx[8*s +: 8], ev);
        end
        if (!bad && nb != 0) chk({cop, caddr, cdata}, {ab[7], ab[6:2], db});
        chk(64'(ncmd - c0), 64'(!bad && nb != 0));
        exp_err = exp_err | bad;
        chk(perr, exp_err);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        #300_000;
        num_errors++;
        complete_run();
    end
    initial begin
        status = 7'h00;
        clr = 1'b0;
        fevt = 1'b0;
        freg = 5'h00;
        len = 4'h1;
        off = 4'h0;
        for (int i = 0; i < 32; i++) regs[i] = 8'(rnd());
        repeat (12) @(negedge clk);
        chk(global_error_flag, 1'b1);
        arst_n = 1'b1;
        repeat (8) @(negedge clk);
        chk(global_error_flag, 1'b1);
        cmd(0, 64'h0);
        for (int i = 0; i < 10; i++) begin
            r = rnd();
            status = r[22:16];
            cmd(i == 8 ? 15 : i == 9 ? 24 : 16, {48'h0, r[15:8], r[7:2], i != 6, i != 7});
        end
        cmd(16, {48'h0, r[15:8], 8'h0B});
        @(negedge clk) clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        exp_err = 1'b0;
        repeat (2) @(negedge clk);
        chk(perr, 1'b0);
        fork
            cmd(16, {48'h0, r[31:24], 8'h97});
            begin
                repeat (180) @(negedge clk);
                fevt = 1'b1;
                freg = 5'h05;
                status = status ^ 7'h01;
                // Top bit of the response is shifted out after this fault.
                regs[5] = regs[5] ^ 8'h80;
                @(negedge clk) fevt = 1'b0;
            end
        join
        chk(cblk, 1'b1);
        cmd(16, {48'h0, r[31:24], 8'h17});
        chk(cblk, 1'b0);
        len = 4'h2;
        cmd(32, {32'h0, r[31:16], 8'h0F, 8'h0D});
        off = 4'h1;
        cmd(32, {32'h0, r[31:24], 8'h0F, 8'h0D, r[7:0]});
        complete_run();
    end
endmodule // spi_frame_daisy_chain_slave_tb
`default_nettype wire
